//--- src/adc_conversion_sequencer.sv
// Conversion sequencer for the general-purpose converter
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - On-demand start accepted only while enabled; converts selected channel
// - Channel 0 conversions drive the configured current source
// - Converter powers per request, or stays on while force-on set
// - On-demand done interrupt reaches host only when unmasked
// - Start bit begins one conversion; completion sets done flag
// - Result: high[3:0] holds upper four bits, low[7:0] lower eight
// - Periodic conversions use slot channel, repeating at programmed rate
// - Each periodic result is compared against split 12-bit threshold
// - Polarity bit selects above-threshold or below-threshold event
// - Slot runs only when enabled; interrupt forwarded when unmasked
// - Threshold crossing sets slot status flag and raises interrupt
// - Periodic results readable from slot result high and low
// - With shutdown bit set, crossing also requests device shutdown
// - Switch-off follows delay unless the interrupt is cleared first
// - Two identical periodic slots; own channel, threshold and enable, shared rate
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int POWERUP_CYCLES = 16,
  parameter int SWOFF_COUNT    = SWOFF_CYCLES
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Analog converter core
  output logic             o_conv_power,
  output logic             o_conv_start,
  output logic      [3:0]  o_conv_channel,
  output logic      [2:0]  o_current_source,
  input  wire logic        i_conv_done,
  input  wire logic [11:0] i_conv_code,
  // System
  output logic             o_irq,
  output logic             o_shutdown_request,
  output logic             o_switch_off
);
  logic [7:0]  sel_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  status_reg;
  logic [7:0]  psel_reg;
  logic [7:0]  pctrl_reg;
  logic [11:0] od_result_reg;
  logic [7:0]  thr_high_reg [2];
  logic [7:0]  thr_low_reg [2];
  logic [11:0] slot_result_reg [2];
  logic        od_pending_reg;
  logic [1:0]  slot_pending_reg;
  logic [1:0]  owner_reg;
  conv_state_t state_reg;
  logic [15:0] pwr_cnt_reg;
  logic [23:0] rate_cnt_reg;
  logic        shutdown_armed_reg;
  logic [31:0] swoff_cnt_reg;
  logic        od_start;
  logic        tick;
  logic        done_od;
  logic        done_a;
  logic        done_b;
  logic [1:0]  crossing;
  logic        sd_hit;
  logic        sd_flag_live;
  logic [7:0]  status_clear;
  logic [23:0] rate_limit;

  function automatic logic is_slot(input logic [7:0] a, input int s,
                                   input logic [7:0] off);
    return a == ADDR_SLOT_BASE + SLOT_STRIDE * 8'(s) + off;
  endfunction

  function automatic logic crosses(input logic [11:0] res,
                                   input logic [7:0] hi,
                                   input logic [7:0] lo);
    logic [11:0] thr;
    thr = {hi[3:0], lo};
    return hi[THR_POL_BIT] ? (res < thr) : (res > thr);
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] target);
    return wr && a == target;
  endfunction

  // Upper four result bits, zero-padded to a register byte
  function automatic logic [7:0] result_high(input logic [11:0] res);
    return {4'h0, res[11:8]};
  endfunction

  assign od_start = wr_hit(i_wr, i_addr, ADDR_ONDEMAND_SELECT)
                    && i_wdata[SEL_START_BIT]
                    && (i_wdata[SEL_EN_BIT] || sel_reg[SEL_EN_BIT]);
  assign done_od = state_reg == ST_CONVERT && i_conv_done && owner_reg == 2'd0;
  assign done_a  = state_reg == ST_CONVERT && i_conv_done && owner_reg == 2'd1;
  assign done_b  = state_reg == ST_CONVERT && i_conv_done && owner_reg == 2'd2;
  // Compare the incoming code, the same value that lands in the result
  assign crossing[0] = done_a &&
    crosses(i_conv_code, thr_high_reg[0], thr_low_reg[0]);
  assign crossing[1] = done_b &&
    crosses(i_conv_code, thr_high_reg[1], thr_low_reg[1]);
  assign rate_limit = 24'(RATE_BASE_CYCLES) *
                      {20'h0, pctrl_reg[PCTRL_RATE_LSB +: 4]} +
                      24'(RATE_BASE_CYCLES - 1);
  assign tick = rate_cnt_reg >= rate_limit;
  // Write-one-to-clear: flags set meanwhile survive a software clear
  assign status_clear = wr_hit(i_wr, i_addr, ADDR_IRQ_STATUS) ?
                        i_wdata : 8'h00;
  // Only slots with shutdown enabled may arm or hold the switch-off
  assign sd_hit       = |(crossing & pctrl_reg[PCTRL_SD_LSB +: 2]);
  assign sd_flag_live = |(status_reg[2:1] & pctrl_reg[PCTRL_SD_LSB +: 2]);

  // Register writes
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_reg   <= 8'h00;
      ctrl_reg  <= 8'h00;
      mask_reg  <= MASK_RESET;
      psel_reg  <= 8'h00;
      pctrl_reg <= 8'h00;
      thr_high_reg <= '{8'h00, 8'h00};
      thr_low_reg  <= '{8'h00, 8'h00};
    end else if (i_wr) begin
      if (i_addr == ADDR_ONDEMAND_SELECT) begin
        // Start bit is self-clearing
        sel_reg <= i_wdata & ~(8'h01 << SEL_START_BIT);
      end else if (i_addr == ADDR_CONVERTER_CTRL) begin
        ctrl_reg <= i_wdata;
      end else if (i_addr == ADDR_IRQ_MASK) begin
        mask_reg <= i_wdata;
      end else if (i_addr == ADDR_PERIODIC_SEL) begin
        psel_reg <= i_wdata;
      end else if (i_addr == ADDR_PERIODIC_CTRL) begin
        pctrl_reg <= i_wdata;
      end else begin
        for (int s = 0; s < 2; s++) begin
          if (is_slot(i_addr, s, SLOT_THR_HIGH)) begin
            thr_high_reg[s] <= i_wdata;
          end
          if (is_slot(i_addr, s, SLOT_THR_LOW)) begin
            thr_low_reg[s] <= i_wdata;
          end
        end
      end
    end
  end

  // Free-running divider: one timebase shared by both slots
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rate_cnt_reg <= 24'h0;
    end else begin
      rate_cnt_reg <= tick ? 24'h0 : rate_cnt_reg + 24'h1;
    end
  end

  // On-demand request, held until the sequencer is idle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      od_pending_reg <= 1'b0;
    end else if (od_start) begin
      od_pending_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && od_pending_reg) begin
      od_pending_reg <= 1'b0;
    end
  end

  // Periodic requests; on-demand is served first
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      slot_pending_reg <= 2'b00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (tick && pctrl_reg[PCTRL_EN_LSB + s]) begin
          slot_pending_reg[s] <= 1'b1;
        end else if (!pctrl_reg[PCTRL_EN_LSB + s]) begin
          slot_pending_reg[s] <= 1'b0;
        end else if (state_reg == ST_IDLE && !od_pending_reg &&
                     (s == 0 || !slot_pending_reg[0])) begin
          slot_pending_reg[s] <= 1'b0;
        end
      end
    end
  end

  // Converter sequencing
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg      <= ST_IDLE;
      owner_reg      <= 2'd0;
      pwr_cnt_reg    <= 16'h0;
      o_conv_start   <= 1'b0;
      o_conv_channel <= 4'h0;
    end else begin
      o_conv_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          pwr_cnt_reg <= 16'h0;
          if (od_pending_reg) begin
            owner_reg      <= 2'd0;
            o_conv_channel <= sel_reg[SEL_CHAN_LSB +: 4];
            state_reg      <= ST_POWERUP;
          end else if (slot_pending_reg[0]) begin
            owner_reg      <= 2'd1;
            o_conv_channel <= psel_reg[3:0];
            state_reg      <= ST_POWERUP;
          end else if (slot_pending_reg[1]) begin
            owner_reg      <= 2'd2;
            o_conv_channel <= psel_reg[7:4];
            state_reg      <= ST_POWERUP;
          end
        end
        ST_POWERUP: begin
          // Forced-on converter is already settled
          if (ctrl_reg[CTRL_FORCE_BIT] ||
              pwr_cnt_reg >= 16'(POWERUP_CYCLES - 1)) begin
            o_conv_start <= 1'b1;
            state_reg    <= ST_CONVERT;
          end
          pwr_cnt_reg <= pwr_cnt_reg + 16'h1;
        end
        ST_CONVERT: begin
          if (i_conv_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Per-request power saves current; force trades it for latency
  assign o_conv_power = ctrl_reg[CTRL_FORCE_BIT] ||
                        state_reg != ST_IDLE;
  assign o_current_source = (state_reg != ST_IDLE && o_conv_channel == 4'h0)
                            ? ctrl_reg[CTRL_ISRC_LSB +: 3] : 3'h0;

  // Results: raw 12-bit code, full scale over 4096 steps
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      od_result_reg   <= 12'h0;
      slot_result_reg <= '{12'h0, 12'h0};
    end else begin
      if (done_od) begin
        od_result_reg <= i_conv_code;
      end
      if (done_a) begin
        slot_result_reg[0] <= i_conv_code;
      end
      if (done_b) begin
        slot_result_reg[1] <= i_conv_code;
      end
    end
  end

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= (status_reg & ~status_clear) |
                    {5'h0, crossing, done_od};
    end
  end

  assign o_irq = |(status_reg[2:0] & ~mask_reg[2:0]);

  // Shutdown request and switch-off delay
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      shutdown_armed_reg <= 1'b0;
      swoff_cnt_reg      <= 32'h0;
      o_switch_off       <= 1'b0;
    end else begin
      if (sd_hit) begin
        shutdown_armed_reg <= 1'b1;
        swoff_cnt_reg      <= 32'h0;
      end else if (shutdown_armed_reg && !sd_flag_live) begin
        // Clearing the flag in time cancels the pending switch-off
        shutdown_armed_reg <= 1'b0;
      end else if (shutdown_armed_reg) begin
        if (swoff_cnt_reg >= 32'(SWOFF_COUNT - 1)) begin
          o_switch_off <= 1'b1;
        end else begin
          swoff_cnt_reg <= swoff_cnt_reg + 32'h1;
        end
      end
    end
  end

  assign o_shutdown_request = shutdown_armed_reg;

  // Read data one cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == ADDR_ONDEMAND_SELECT) begin
        o_rdata <= sel_reg;
      end else if (i_addr == ADDR_CONVERTER_CTRL) begin
        o_rdata <= ctrl_reg;
      end else if (i_addr == ADDR_IRQ_MASK) begin
        o_rdata <= mask_reg;
      end else if (i_addr == ADDR_IRQ_STATUS) begin
        o_rdata <= status_reg;
      end else if (i_addr == ADDR_OD_RESULT_HIGH) begin
        o_rdata <= result_high(od_result_reg);
      end else if (i_addr == ADDR_OD_RESULT_LOW) begin
        o_rdata <= od_result_reg[7:0];
      end else if (i_addr == ADDR_PERIODIC_SEL) begin
        o_rdata <= psel_reg;
      end else if (i_addr == ADDR_PERIODIC_CTRL) begin
        o_rdata <= pctrl_reg;
      end else if (is_slot(i_addr, 0, SLOT_THR_HIGH)) begin
        o_rdata <= thr_high_reg[0];
      end else if (is_slot(i_addr, 0, SLOT_THR_LOW)) begin
        o_rdata <= thr_low_reg[0];
      end else if (is_slot(i_addr, 0, SLOT_RES_HIGH)) begin
        o_rdata <= result_high(slot_result_reg[0]);
      end else if (is_slot(i_addr, 0, SLOT_RES_LOW)) begin
        o_rdata <= slot_result_reg[0][7:0];
      end else if (is_slot(i_addr, 1, SLOT_THR_HIGH)) begin
        o_rdata <= thr_high_reg[1];
      end else if (is_slot(i_addr, 1, SLOT_THR_LOW)) begin
        o_rdata <= thr_low_reg[1];
      end else if (is_slot(i_addr, 1, SLOT_RES_HIGH)) begin
        o_rdata <= result_high(slot_result_reg[1]);
      end else if (is_slot(i_addr, 1, SLOT_RES_LOW)) begin
        o_rdata <= slot_result_reg[1][7:0];
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      // Idle bus reads as zero, so stale data never lingers
      o_rdata <= 8'h00;
    end
  end
endmodule // adc_conversion_sequencer

//--- src/adc_seq_pkg.sv
// Constants for the converter sequencer: register map, fields, timing
package adc_seq_pkg;
  localparam logic [7:0] ADDR_ONDEMAND_SELECT = 8'h00;
  localparam logic [7:0] ADDR_CONVERTER_CTRL = 8'h01;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h02;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h03;
  localparam logic [7:0] ADDR_OD_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_OD_RESULT_LOW  = 8'h05;
  localparam logic [7:0] ADDR_PERIODIC_SEL   = 8'h06;
  localparam logic [7:0] ADDR_PERIODIC_CTRL  = 8'h07;
  localparam logic [7:0] ADDR_SLOT_BASE      = 8'h08;
  localparam logic [7:0] SLOT_STRIDE         = 8'h04;
  localparam logic [7:0] SLOT_THR_HIGH       = 8'h00;
  localparam logic [7:0] SLOT_THR_LOW        = 8'h01;
  localparam logic [7:0] SLOT_RES_HIGH       = 8'h02;
  localparam logic [7:0] SLOT_RES_LOW        = 8'h03;
  // ondemand_select_register fields
  localparam int SEL_CHAN_LSB  = 0;
  localparam int SEL_EN_BIT    = 4;
  localparam int SEL_START_BIT = 5;
  // converter_control_register fields
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_ISRC_LSB  = 1;
  // three interrupt mask/status bits
  localparam int IRQ_OD_BIT    = 0;
  localparam int IRQ_SLOT_LSB  = 1;
  // periodic_control_register fields
  localparam int PCTRL_RATE_LSB = 0;
  localparam int PCTRL_EN_LSB   = 4;
  localparam int PCTRL_SD_LSB   = 6;
  // Polarity bit in threshold high register
  localparam int THR_POL_BIT    = 7;
  localparam logic [7:0] MASK_RESET = 8'h07;
  // Switch-off delay
  localparam int SWOFF_DELAY_US = 1000;
  localparam int CLK_MHZ        = 125;
  localparam int SWOFF_CYCLES   = SWOFF_DELAY_US * CLK_MHZ;
  localparam int RATE_BASE_CYCLES = 1024;
  typedef enum {ST_IDLE, ST_POWERUP, ST_CONVERT} conv_state_t;
endpackage

//--- test/adc_conversion_sequencer_assertions.sv
// Port-level checker for the conversion sequencer
`timescale 1ns/100ps
module adc_conversion_sequencer_checker #(
  parameter int POWERUP_CYCLES = 16,
  parameter int SWOFF_COUNT    = 125000
) (
  // Clock, reset and bus
  input logic       i_sys_clk,
  input logic       i_reset,
  input logic       i_wr,
  input logic       i_rd,
  input logic [7:0] o_rdata,
  // Converter core
  input logic       o_conv_power,
  input logic       o_conv_start,
  input logic [3:0] o_conv_channel,
  input logic [2:0] o_current_source,
  input logic       i_conv_done,
  // System
  input logic       o_irq,
  input logic       o_shutdown_request,
  input logic       o_switch_off
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  int req_cnt;
  // Held past switch-off so a dropped request cannot hide the wait
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset)
      req_cnt <= 0;
    else if (!o_shutdown_request && !o_switch_off)
      req_cnt <= 0;
    else if (o_shutdown_request && req_cnt < 1000000)
      req_cnt <= req_cnt + 1;
  end
  sequence s_launch;
    o_conv_start ##1 !o_conv_start;
  endsequence
  start_pulse_a: assert property (o_conv_start |-> s_launch)
    else $error("start pulse longer than one cycle");
  start_power_a: assert property (
    o_conv_start |-> o_conv_power && $past(o_conv_power))
    else $error("start without converter power");
  isrc_chan0_a: assert property (
    o_current_source != 3'h0 |-> o_conv_channel == 4'h0 && o_conv_power)
    else $error("current source off channel zero");
  power_hold_a: assert property (
    $rose(o_conv_power) |-> o_conv_power [*3])
    else $error("converter power dropped early");
  irq_hold_a: assert property (o_irq && !i_wr |=> o_irq)
    else $error("interrupt dropped without a write");
  irq_cause_a: assert property (
    $rose(o_irq) |-> $past(i_wr) || $past(i_conv_done))
    else $error("interrupt rose without cause");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  swoff_sticky_a: assert property (o_switch_off |=> o_switch_off)
    else $error("switch-off released");
  swoff_cause_a: assert property (
    $rose(o_switch_off) |-> $past(o_shutdown_request))
    else $error("switch-off without request");
  swoff_delay_a: assert property (
    $rose(o_switch_off) |-> req_cnt >= SWOFF_COUNT)
    else $error("switch-off before the delay");
endmodule // adc_conversion_sequencer_checker

bind adc_conversion_sequencer adc_conversion_sequencer_checker #(
  .POWERUP_CYCLES(POWERUP_CYCLES), .SWOFF_COUNT(SWOFF_COUNT)) i_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_conv_power(o_conv_power),
  .o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel),
  .o_current_source(o_current_source), .i_conv_done(i_conv_done),
  .o_irq(o_irq), .o_shutdown_request(o_shutdown_request),
  .o_switch_off(o_switch_off));

//--- test/adc_conversion_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module adc_conversion_sequencer_tb_top import adc_seq_pkg::*;;
  localparam logic [7:0] SA = ADDR_SLOT_BASE;
  localparam logic [7:0] SB = ADDR_SLOT_BASE + SLOT_STRIDE;
  logic        i_sys_clk, i_reset, i_wr, i_rd, i_conv_done;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic        o_conv_power, o_conv_start, o_irq;
  logic        o_shutdown_request, o_switch_off;
  logic [3:0]  o_conv_channel;
  logic [2:0]  o_current_source;
  logic [11:0] i_conv_code;
  int          n_fail, cmp_count, cycles, t0;
  logic        seen;
  adc_conversion_sequencer #(.POWERUP_CYCLES(4), .SWOFF_COUNT(20))
    i_adc_conversion_sequencer (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_conv_power(o_conv_power),
    .o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel),
    .o_current_source(o_current_source), .i_conv_done(i_conv_done),
    .i_conv_code(i_conv_code), .o_irq(o_irq),
    .o_shutdown_request(o_shutdown_request), .o_switch_off(o_switch_off));
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Six periodic ticks, two at double period, plus margin
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    cmp8(o_rdata, exp);
  endtask
  task automatic wait_start(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(negedge i_sys_clk);
      if (o_conv_start === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask
  task automatic finish_conv(input logic [11:0] c);
    @(posedge i_sys_clk);
    i_conv_done <= 1'b1;
    i_conv_code <= c;
    @(posedge i_sys_clk);
    i_conv_done <= 1'b0;
  endtask
  initial begin
    {i_wr, i_rd, i_conv_done, i_addr, i_wdata, i_conv_code} = '0;
    i_reset = 1'b1;
    {n_fail, cmp_count, cycles} = '0;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd(ADDR_IRQ_MASK, MASK_RESET);
    cmp1(o_conv_power, 1'b0);
    wr(ADDR_ONDEMAND_SELECT, 8'h20);
    wait_start(40);
    cmp1(seen, 1'b0);
    wr(ADDR_CONVERTER_CTRL, 8'h0a);
    wr(ADDR_ONDEMAND_SELECT, 8'h30);
    wait_start(40);
    cmp1(seen, 1'b1);
    cmp8({5'h0, o_current_source}, 8'h05);
    finish_conv(12'habc);
    rd(ADDR_IRQ_STATUS, 8'h01);
    cmp1(o_irq, 1'b0);
    cmp1(o_conv_power, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h06);
    rd(ADDR_OD_RESULT_HIGH, 8'h0a);
    cmp1(o_irq, 1'b1);
    rd(ADDR_OD_RESULT_LOW, 8'hbc);
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONVERTER_CTRL, 8'h01);
    @(negedge i_sys_clk);
    cmp1(o_irq, 1'b0);
    cmp1(o_conv_power, 1'b1);
    wr(ADDR_ONDEMAND_SELECT, 8'h33);
    wait_start(40);
    cmp8({4'h0, o_conv_channel}, 8'h03);
    cmp8({5'h0, o_current_source}, 8'h00);
    finish_conv(12'h5a5);
    rd(ADDR_OD_RESULT_LOW, 8'ha5);
    wr(ADDR_CONVERTER_CTRL, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_PERIODIC_SEL, 8'h52);
    wr(SA + SLOT_THR_HIGH, 8'h01);
    wr(SA + SLOT_THR_LOW, 8'h00);
    wr(SB + SLOT_THR_HIGH, 8'h88);
    wr(SB + SLOT_THR_LOW, 8'h00);
    wait_start(1100);
    cmp1(seen, 1'b0);
    wr(ADDR_PERIODIC_CTRL, 8'h20);
    wait_start(2100);
    cmp8({4'h0, o_conv_channel}, 8'h05);
    finish_conv(12'h7ff);
    rd(ADDR_IRQ_STATUS, 8'h04);
    cmp1(o_irq, 1'b1);
    cmp1(o_shutdown_request, 1'b0);
    rd(SB + SLOT_RES_HIGH, 8'h07);
    rd(SB + SLOT_RES_LOW, 8'hff);
    wr(ADDR_PERIODIC_CTRL, 8'h50);
    wr(ADDR_IRQ_STATUS, 8'h04);
    wait_start(2100);
    cmp8({4'h0, o_conv_channel}, 8'h02);
    finish_conv(12'h200);
    rd(ADDR_IRQ_STATUS, 8'h02);
    cmp1(o_irq, 1'b0);
    cmp1(o_shutdown_request, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h02);
    repeat (30) @(negedge i_sys_clk);
    cmp1(o_switch_off, 1'b0);
    wait_start(2100);
    finish_conv(12'h080);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(SA + SLOT_RES_LOW, 8'h80);
    wait_start(2100);
    finish_conv(12'h101);
    rd(SA + SLOT_RES_HIGH, 8'h01);
    repeat (30) @(negedge i_sys_clk);
    cmp1(o_switch_off, 1'b1);
    wr(ADDR_PERIODIC_CTRL, 8'h11);
    wait_start(2100);
    t0 = cycles;
    finish_conv(12'h000);
    wait_start(2100);
    cmp1(seen, 1'b1);
    cmp1((cycles - t0) == 2 * RATE_BASE_CYCLES, 1'b1);
    wr(ADDR_PERIODIC_CTRL, 8'h00);
    rd(8'h40, 8'h00);
    test_done;
  end
endmodule // adc_conversion_sequencer_tb_top
